// ===== sdpr_pkg.sv
package sdpr_pkg;

  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 17;
  localparam int DATA_W = 9;
  localparam int WORDS = 131072;
  localparam int NPORTS = 2;

  // ---------------------------------------------------------------
  // counter and latency constants
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 17'h00000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 17'h00001;
  localparam logic LAT_FLOW = 1'h0;
  localparam logic LAT_PIPE = 1'h1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 9'h000;

  // ---------------------------------------------------------------
  // pins of one port, as seen by the array
  // ---------------------------------------------------------------
  typedef struct packed {
    logic portClock;
    logic selectActiveLow;
    logic selectActiveHigh;
    logic writeNotRead;
    logic outputEnableN;
    logic addressStrobeN;
    logic countAdvanceN;
    logic countClearN;
    logic outputLatencySelect;
    logic [ADDR_W-1:0] wordAddress;
    logic [DATA_W-1:0] dataIn;
  } sdpr_port_in_t;

  // ---------------------------------------------------------------
  // state of one port
  // ---------------------------------------------------------------
  typedef struct packed {
    logic clkPrev;
    logic act;
    logic capSelected;
    logic capWrite;
    logic [DATA_W-1:0] capData;
    logic [ADDR_W-1:0] addr;
    logic flowValid;
    logic [DATA_W-1:0] flowData;
    logic pipeValid;
    logic [DATA_W-1:0] pipeData;
    logic outDrive;
    logic [DATA_W-1:0] outData;
  } sdpr_port_st_t;

  typedef struct packed {
    sdpr_port_st_t [NPORTS-1:0] port;
  } sdpr_state_t;

endpackage

// ===== sdpr_dual_port_ram.sv
// Functional notes
// - both ports reach any word at once, each on its own port clock
// - array of 128K words, 9 bits, 17-bit address per port
// - address, data and controls are captured on the port clock rising edge
// - inactive select at the edge deselects the port and floats its data lines
// - selected with write-not-read low writes captured data, output enable ignored
// - selected, write-not-read high and output enable low drives the read word
// - output enable high floats the data lines at once, independent of clock
// - each port picks flow-through or pipelined timing by its latency select
// - pipelined mode adds one port clock of delay through an output register
// - counter clear low forces the internal address to zero, overriding the rest
// - address strobe low loads the external address and uses it
// - strobe and advance both high reuse the previous internal address
// - advance low with strobe high uses previous address plus one
// - clear acts regardless of the selects and other inputs, strobe regardless of all but clear
// - counter advances even while the port is deselected
`timescale 1ns/1ps
`default_nettype none

module sdpr_dual_port_ram #(
  parameter int DATA_W = sdpr_pkg::DATA_W,
  parameter int WORDS = sdpr_pkg::WORDS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // port pins, index 0 left, index 1 right
  input wire sdpr_pkg::sdpr_port_in_t [sdpr_pkg::NPORTS-1:0] portIn,
  // data lines toward each port
  output logic [sdpr_pkg::NPORTS-1:0][sdpr_pkg::DATA_W-1:0] dataLinesOut,
  output logic [sdpr_pkg::NPORTS-1:0] dataLinesOe
);

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  logic rstSync1_r;
  logic rstSync2_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstSync1_r <= 1'h0;
      rstSync2_r <= 1'h0;
    end else begin
      rstSync1_r <= 1'h1;
      rstSync2_r <= rstSync1_r;
    end
  end

  // ---------------------------------------------------------------
  // shared array
  // ---------------------------------------------------------------
  logic [sdpr_pkg::DATA_W-1:0] mem [WORDS];

  sdpr_pkg::sdpr_state_t state_r;
  sdpr_pkg::sdpr_state_t state_nxt;
  logic [sdpr_pkg::NPORTS-1:0] portEdge;
  logic [sdpr_pkg::NPORTS-1:0][sdpr_pkg::DATA_W-1:0] readWord;

  // each port reads and writes through its own path
  always_ff @(posedge clk) begin
    for (int p = 0; p < sdpr_pkg::NPORTS; p++) begin
      if (state_r.port[p].act && state_r.port[p].capSelected
          && state_r.port[p].capWrite) begin
        mem[state_r.port[p].addr] <= state_r.port[p].capData;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < sdpr_pkg::NPORTS; p++) begin
      readWord[p] = mem[state_r.port[p].addr];
    end
  end

  // ---------------------------------------------------------------
  // port sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    portEdge = '0;
    for (int p = 0; p < sdpr_pkg::NPORTS; p++) begin
      state_nxt.port[p].clkPrev = portIn[p].portClock;
      portEdge[p] = portIn[p].portClock & ~state_r.port[p].clkPrev;
      state_nxt.port[p].act = portEdge[p];

      // capture on the port clock rising edge
      if (portEdge[p]) begin
        state_nxt.port[p].capSelected = ~portIn[p].selectActiveLow
          & portIn[p].selectActiveHigh;
        state_nxt.port[p].capWrite = ~portIn[p].writeNotRead;
        state_nxt.port[p].capData = portIn[p].dataIn;
        // counter control ignores the selects
        if (!portIn[p].countClearN) begin
          state_nxt.port[p].addr = sdpr_pkg::ADDR_ZERO;
        end else if (!portIn[p].addressStrobeN) begin
          state_nxt.port[p].addr = portIn[p].wordAddress;
        end else if (!portIn[p].countAdvanceN) begin
          state_nxt.port[p].addr = state_r.port[p].addr
            + sdpr_pkg::ADDR_ONE;
        end else begin
          state_nxt.port[p].addr = state_r.port[p].addr;
        end
        // pipelined stage moves one port clock behind the flow stage
        state_nxt.port[p].pipeValid = state_r.port[p].flowValid;
        state_nxt.port[p].pipeData = state_r.port[p].flowData;
      end

      // act on the captured values one cycle later
      if (state_r.port[p].act) begin
        state_nxt.port[p].flowValid = state_r.port[p].capSelected
          & ~state_r.port[p].capWrite;
        if (state_r.port[p].capSelected && !state_r.port[p].capWrite) begin
          state_nxt.port[p].flowData = readWord[p];
        end
      end

      // latency select chooses which stage feeds the data lines
      if (portIn[p].outputLatencySelect == sdpr_pkg::LAT_PIPE) begin
        state_nxt.port[p].outDrive = state_r.port[p].pipeValid;
        state_nxt.port[p].outData = state_r.port[p].pipeData;
      end else begin
        state_nxt.port[p].outDrive = state_r.port[p].flowValid;
        state_nxt.port[p].outData = state_r.port[p].flowData;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstSync2_r) begin
    if (!rstSync2_r) begin
      for (int p = 0; p < sdpr_pkg::NPORTS; p++) begin
        state_r.port[p].clkPrev <= 1'h1;
        state_r.port[p].act <= 1'h0;
        state_r.port[p].capSelected <= 1'h0;
        state_r.port[p].capWrite <= 1'h0;
        state_r.port[p].capData <= sdpr_pkg::DATA_ZERO;
        state_r.port[p].addr <= sdpr_pkg::ADDR_ZERO;
        state_r.port[p].flowValid <= 1'h0;
        state_r.port[p].flowData <= sdpr_pkg::DATA_ZERO;
        state_r.port[p].pipeValid <= 1'h0;
        state_r.port[p].pipeData <= sdpr_pkg::DATA_ZERO;
        state_r.port[p].outDrive <= 1'h0;
        state_r.port[p].outData <= sdpr_pkg::DATA_ZERO;
      end
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // data line drive, output enable gates without the clock
  // ---------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < sdpr_pkg::NPORTS; p++) begin
      dataLinesOut[p] = state_r.port[p].outData;
      dataLinesOe[p] = state_r.port[p].outDrive
        & ~portIn[p].outputEnableN;
    end
  end

endmodule

`default_nettype wire

// ===== sdpr_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sdpr_chk (
  // clock and pins
  input wire logic clk,
  input wire logic rst_b,
  input wire sdpr_pkg::sdpr_port_in_t [1:0] portIn,
  input wire logic [1:0][8:0] dataLinesOut,
  input wire logic [1:0] dataLinesOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  function automatic logic sel(input sdpr_pkg::sdpr_port_in_t s);
    return !s.selectActiveLow && s.selectActiveHigh;
  endfunction
  sequence edgeIn(p, l);
    $rose(portIn[p].portClock) && portIn[p].outputLatencySelect == l;
  endsequence
  sequence rdIn(p, l);
    edgeIn(p, l) ##0 (sel(portIn[p]) && portIn[p].writeNotRead);
  endsequence
  rd_drive_a: assert property (rdIn(0, 0) ##3 !portIn[0].outputEnableN |-> dataLinesOe[0])
    else $error("read not driven");
  desel_float_a: assert property (edgeIn(0, 0) ##0 !sel(portIn[0]) |-> ##3 !dataLinesOe[0])
    else $error("deselected port drives");
  wr_float_a: assert property (edgeIn(0, 0) ##0 !portIn[0].writeNotRead |-> ##3 !dataLinesOe[0])
    else $error("write drives lines");
  pipe_late_a: assert property (rdIn(1, 1) ##4 edgeIn(1, 1) ##2 !portIn[1].outputEnableN
    |-> dataLinesOe[1]) else $error("pipelined read not driven");
  oe0_off_a: assert property (portIn[0].outputEnableN |-> !dataLinesOe[0])
    else $error("port 0 drives while disabled");
  oe1_off_a: assert property (portIn[1].outputEnableN |-> !dataLinesOe[1])
    else $error("port 1 drives while disabled");
  hold0_a: assert property ((!$rose(portIn[0].portClock)) [*5] |=> $stable(dataLinesOut[0]))
    else $error("port 0 data changed without access");
  hold1_a: assert property ((!$rose(portIn[1].portClock)) [*5] |=> $stable(dataLinesOut[1]))
    else $error("port 1 data changed without access");
endmodule
bind sdpr_dual_port_ram sdpr_chk chk_u (.clk(clk), .rst_b(rst_b), .portIn(portIn),
  .dataLinesOut(dataLinesOut), .dataLinesOe(dataLinesOe));
`default_nettype wire

// ===== sdpr_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdpr_host #(
  parameter logic LAT = sdpr_pkg::LAT_FLOW
) (
  // clock and port pins
  input wire logic clk,
  output var sdpr_pkg::sdpr_port_in_t pins
);
  initial begin
    pins = '1;
    pins.portClock = 1'b0;
    pins.outputLatencySelect = LAT;
  end
  // one access: port clock low two cycles, high two, pins held through the edge
  task automatic acc(input logic [5:0] c, input logic [16:0] a, input logic [8:0] d);
    @(negedge clk);
    pins.portClock = 1'b0;
    pins.outputEnableN = c[5];
    pins.selectActiveLow = c[4] & a[0];
    pins.selectActiveHigh = !(c[4] & !a[0]);
    {pins.writeNotRead, pins.addressStrobeN, pins.countAdvanceN, pins.countClearN} = c[3:0];
    pins.wordAddress = a;
    pins.dataIn = d;
    repeat (2) @(negedge clk);
    pins.portClock = 1'b1;
    @(negedge clk);
    pins.wordAddress = ~a;
    pins.dataIn = ~d;
  endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----
  // codes {oeN, deselect, writeNotRead, strobeN, advanceN, clearN}
  // ----
  localparam logic [5:0] WR_LD = 6'h03, WR_INC = 6'h05, RD_LD = 6'h0B, RD_INC = 6'h0D;
  localparam logic [5:0] RD_HOLD = 6'h0F, RD_CLR = 6'h08, DS_INC = 6'h1D, DS_LD = 6'h1B;
  localparam logic [5:0] RD_OFF = 6'h2B;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  sdpr_pkg::sdpr_port_in_t pin0, pin1;
  wire sdpr_pkg::sdpr_port_in_t [1:0] pins = {pin1, pin0};
  logic [1:0][8:0] dOut;
  logic [1:0] dOe;
  int err_total = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'hB47C;
  logic [16:0] cnt [2] = '{17'h00000, 17'h00000};
  logic [8:0] mem [logic [16:0]];
  logic [8:0] expQ [2][$];
  logic [16:0] base;
  always #12.5 clk = ~clk;
  sdpr_host #(.LAT(sdpr_pkg::LAT_FLOW)) host0 (.clk(clk), .pins(pin0));
  sdpr_host #(.LAT(sdpr_pkg::LAT_PIPE)) host1 (.clk(clk), .pins(pin1));
  sdpr_dual_port_ram dut_u (.clk(clk), .rst_b(rst_b), .portIn(pins), .dataLinesOut(dOut),
    .dataLinesOe(dOe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input int p);
    logic [8:0] e;
    e = expQ[p].pop_front();
    samples_checked++;
    if (dOe[p] !== 1'b1 || dOut[p] !== e) begin
      err_total++;
      $display("CHECK FAILED read port %0d expected %h seen %h oe %b", p, e, dOut[p], dOe[p]);
    end
  endtask
  // counter and memory model, then the access itself
  task automatic go(input int p, input logic [5:0] c, input logic [16:0] a, input logic [8:0] d);
    if (!c[0]) cnt[p] = 17'h00000;
    else if (!c[2]) cnt[p] = a;
    else if (!c[1]) cnt[p] = cnt[p] + 17'h00001;
    if (!c[4] && !c[3]) mem[cnt[p]] = d;
    if (!c[5] && !c[4] && c[3]) expQ[p].push_back(mem[cnt[p]]);
    if (p == 0) host0.acc(c, a, d);
    else host1.acc(c, a, d);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  for (genvar p = 0; p < 2; p++) begin : g_mon
    logic pv = 1'b1;
    always @(posedge clk) begin
      pv <= pins[p].portClock;
      if (pins[p].portClock && !pv && pins[p].writeNotRead && !pins[p].outputEnableN
          && !pins[p].selectActiveLow && pins[p].selectActiveHigh) fork
        begin
          if (pins[p].outputLatencySelect) @(posedge pins[p].portClock);
          repeat (3) @(posedge clk);
          @(negedge clk);
          check(p);
        end
      join_none
    end
  end
  // 31 accesses of 4 cycles are planned; far more means a hang
  initial begin
    repeat (2000) @(negedge clk);
    err_total++;
    results();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    base = 17'(rnd());
    for (int i = 0; i < 8; i++) go(0, i ? WR_INC : WR_LD, i ? 17'(rnd()) : base, 9'(rnd()));
    for (int i = 0; i < 8; i++) go(1, i ? RD_INC : RD_LD, i ? 17'(rnd()) : base, 9'h000);
    go(0, RD_LD, base, 9'h000);
    go(0, RD_HOLD, 17'(rnd()), 9'h000);
    go(0, DS_INC, 17'(rnd()), 9'h000);
    go(0, RD_INC, 17'(rnd()), 9'h000);
    go(0, DS_LD, base + 17'h00005, 9'h000);
    go(0, RD_HOLD, 17'(rnd()), 9'h000);
    go(0, DS_INC, 17'(rnd()), 9'h000);
    go(0, RD_OFF, base, 9'h000);
    go(0, WR_LD, 17'h1FFFF, 9'(rnd()));
    go(0, WR_INC, 17'(rnd()), 9'(rnd()));
    go(1, RD_LD, 17'h1FFFF, 9'h000);
    go(0, RD_CLR, 17'(rnd()), 9'h000);
    fork
      go(0, WR_LD, 17'(rnd()), 9'(rnd()));
      go(1, RD_LD, base, 9'h000);
    join
    go(1, DS_INC, 17'h00000, 9'h000);
    repeat (8) @(negedge clk);
    results();
  end
endmodule
`default_nettype wire
